/* rtl/acc_clock_select.sv */
// acc_clock_select: source selection and divider making the converter clock enable
`timescale 1ns/1ps
`default_nettype none
module acc_clock_select
    import acc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [1:0] input_clock_select,
    input  wire logic [1:0] clock_divide_select,
    input  wire logic       alternate_clock,
    input  wire logic       converter_async_clock,
    output logic            converter_clock_en
);

    typedef struct packed {
        logic       alt_s1;
        logic       alt_s2;
        logic       alt_s3;
        logic       asy_s1;
        logic       asy_s2;
        logic       asy_s3;
        logic       half;
        logic [2:0] cnt;
        logic       en;
    } acc_clk_state_t;

    acc_clk_state_t st;
    acc_clk_state_t next_st;
    logic           src_pulse;

    // source pulse, then count source pulses up to the divide ratio
    always_comb begin
        next_st        = st;
        next_st.alt_s1 = alternate_clock;
        next_st.alt_s2 = st.alt_s1;
        next_st.alt_s3 = st.alt_s2;
        next_st.asy_s1 = converter_async_clock;
        next_st.asy_s2 = st.asy_s1;
        next_st.asy_s3 = st.asy_s2;
        next_st.half   = ~st.half;
        case (acc_src_t'(input_clock_select)) // [RL9]
            ACC_SRC_BUS:   src_pulse = 1'b1;
            ACC_SRC_HALF:  src_pulse = st.half;
            ACC_SRC_ALT:   src_pulse = st.alt_s2 & ~st.alt_s3;
            ACC_SRC_ASYNC: src_pulse = st.asy_s2 & ~st.asy_s3;
            default:       src_pulse = 1'b0;
        endcase
        next_st.en = 1'b0;
        if (src_pulse) begin
            // a lowered ratio takes effect at once rather than after a long wrap
            if (st.cnt >= acc_div_last(clock_divide_select)) begin // [RL6]
                next_st.cnt = ACC_RST_DIV_CNT;
                next_st.en  = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 3'h1;
            end
        end
    end

    // external clocks are only sampled, so they must stay well below clk / 2
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign converter_clock_en = st.en;

endmodule
`default_nettype wire

/* rtl/acc_compare.sv */
// acc_compare: mode-dependent compare value, condition and difference
`timescale 1ns/1ps
`default_nettype none
module acc_compare
    import acc_pkg::*;
(
    input  wire logic [1:0]  conversion_mode,
    input  wire logic [3:0]  compare_value_high,
    input  wire logic [7:0]  compare_value_low,
    input  wire logic        compare_greater_select,
    input  wire logic [11:0] raw_result,
    output logic             compare_hit,
    output logic [11:0]      compare_diff,
    output logic [11:0]      masked_result
);

    logic [11:0] mask;
    logic [11:0] value;
    logic        below;

    // assemble the compare value from the halves the mode uses
    always_comb begin
        mask  = acc_mode_mask(conversion_mode);
        value = {4'h0, compare_value_low}; // [RL4] [RL3]
        if (conversion_mode == ACC_MODE_12) begin
            value = {compare_value_high, compare_value_low}; // [RL1]
        end else if (conversion_mode == ACC_MODE_10) begin
            value = {2'h0, compare_value_high[1:0], compare_value_low}; // [RL2]
        end
        masked_result = raw_result & mask;
        below         = masked_result < value;
        compare_hit   = compare_greater_select ? ~below : below; // [RL13]
        // result plus two's complement of value, kept to the mode width
        compare_diff  = (masked_result + ~value + 12'h001) & mask; // [RL14]
    end

endmodule
`default_nettype wire

/* rtl/acc_config.sv */
// acc_config: register file, compare capture and pin handover of the converter
// How it works
// RL1 - 12-bit: high register holds four upper bits
// RL2 - 10-bit: high register bits 1:0 used
// RL3 - 8-bit: high register ignored in compare
// RL4 - low register gives compare bits 7:0
// RL5 - config bit 7: 0 speed, 1 low power
// RL6 - config bits 6:5 divide by 1/2/4/8
// RL7 - config bit 4 picks long sample time
// RL8 - bits 3:2: 00 8, 01 12, 10 10-bit
// RL9 - bits 1:0: bus, half, alternate, async clock
// RL10 - low pin register bit n is channel n
// RL11 - mid pin register bit n is channel 8+n
// RL12 - pin bit 1 hands pin to analogue
// RL13 - greater select: 0 below, 1 at-or-above
// RL14 - store only on hit, result minus value
// RL15 - handed pins: high-Z, read zero, no pull-up
// RL16 - all registers reset to zero
// RL17 - compare-high upper bits read zero, ignore writes
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acc_config
    import acc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,

    // axi4-lite slave
    input  wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [ACC_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [ACC_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,

    // converter core
    input  wire logic                  conv_done,
    input  wire logic [11:0]           conv_result,
    input  wire logic                  alternate_clock,
    input  wire logic                  converter_async_clock,
    output logic                       low_power_select,
    output logic                       long_sample_select,
    output logic [1:0]                 conversion_mode,
    output logic                       converter_clock_en,
    output logic                       result_update,

    // port logic and pads, channels 0 to 15
    input  wire logic [15:0]           port_out,
    input  wire logic [15:0]           port_oe_n,
    input  wire logic [15:0]           port_pullup,
    input  wire logic [15:0]           pad_in,
    output logic [15:0]                pad_out,
    output logic [15:0]                pad_oe_n,
    output logic [15:0]                pad_pullup,
    output logic [15:0]                port_in,
    output logic [15:0]                analog_select
);

    typedef struct packed {
        logic                  awready;
        logic                  aw_held;
        logic [ACC_ADDR_W-1:0] aw_addr;
        logic                  wready;
        logic                  w_held;
        logic [7:0]            w_data;
        logic                  w_lane0;
        logic                  bvalid;
        logic [1:0]            bresp;

        logic                  arready;
        logic                  rvalid;
        logic [ACC_DATA_W-1:0] rdata;
        logic [1:0]            rresp;

        logic [3:0]            cmp_high;
        logic [7:0]            cmp_low;
        logic [7:0]            config_reg;
        logic [7:0]            pin_low;
        logic [7:0]            pin_mid;
        logic [1:0]            cmp_ctrl;

        logic [11:0]           result;
        logic                  result_update;

        logic [15:0]           pad_s1;
        logic [15:0]           pad_s2;

        logic [15:0]           pad_out;
        logic [15:0]           pad_oe_n;
        logic [15:0]           pad_pullup;
        logic [15:0]           port_in;
    } acc_state_t;

    acc_state_t  st;
    acc_state_t  next_st;

    logic        cmp_hit;
    logic [11:0] cmp_diff;
    logic [11:0] cmp_masked;
    logic [15:0] handed;

    // channel n of the low register, channel 8+n of the mid one
    assign handed = {st.pin_mid, st.pin_low}; // [RL10] [RL11]

    acc_clock_select u_clock_select (
        .clk                   (clk),
        .srst                  (srst),
        .input_clock_select    (st.config_reg[ACC_CFG_CLK_HI:ACC_CFG_CLK_LO]),
        .clock_divide_select   (st.config_reg[ACC_CFG_DIV_HI:ACC_CFG_DIV_LO]),
        .alternate_clock       (alternate_clock),
        .converter_async_clock (converter_async_clock),
        .converter_clock_en    (converter_clock_en)
    );

    acc_compare u_compare (
        .conversion_mode        (st.config_reg[ACC_CFG_MODE_HI:ACC_CFG_MODE_LO]),
        .compare_value_high     (st.cmp_high),
        .compare_value_low      (st.cmp_low),
        .compare_greater_select (st.cmp_ctrl[ACC_CTL_GREATER]),
        .raw_result             (conv_result),
        .compare_hit            (cmp_hit),
        .compare_diff           (cmp_diff),
        .masked_result          (cmp_masked)
    );

    // whole-block next state
    always_comb begin
        next_st = st;

        // write address and data are taken independently, in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end

        if (s_axi_wvalid && st.wready) begin
            next_st.w_held  = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end

        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // commit only once the previous response has drained
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = ACC_RESP_OKAY;

            if (st.aw_addr == ACC_OFS_CMP_HIGH) begin
                if (st.w_lane0) begin
                    // only four bits exist, the rest are dropped
                    next_st.cmp_high = st.w_data[ACC_CMP_HIGH_W-1:0]; // [RL17]
                end
            end else if (st.aw_addr == ACC_OFS_CMP_LOW) begin
                if (st.w_lane0) begin
                    next_st.cmp_low = st.w_data;
                end
            end else if (st.aw_addr == ACC_OFS_CONFIG) begin
                if (st.w_lane0) begin
                    next_st.config_reg = st.w_data; // [RL5] [RL7] [RL8]
                end
            end else if (st.aw_addr == ACC_OFS_PIN_LOW) begin
                if (st.w_lane0) begin
                    next_st.pin_low = st.w_data;
                end
            end else if (st.aw_addr == ACC_OFS_PIN_MID) begin
                if (st.w_lane0) begin
                    next_st.pin_mid = st.w_data;
                end
            end else if (st.aw_addr == ACC_OFS_CMP_CTRL) begin
                if (st.w_lane0) begin
                    next_st.cmp_ctrl = st.w_data[1:0];
                end
            end else if (st.aw_addr == ACC_OFS_RESULT) begin
                // read-only, write is accepted and has no effect
                next_st.bresp = ACC_RESP_OKAY;
            end else begin
                next_st.bresp = ACC_RESP_SLVERR;
            end
        end
        next_st.awready = ~next_st.aw_held;
        next_st.wready  = ~next_st.w_held;

        // read channel, one outstanding read
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = ACC_RESP_OKAY;
            next_st.rdata  = '0;

            if (s_axi_araddr == ACC_OFS_CMP_HIGH) begin
                next_st.rdata[3:0] = st.cmp_high; // [RL17]
            end else if (s_axi_araddr == ACC_OFS_CMP_LOW) begin
                next_st.rdata[7:0] = st.cmp_low;
            end else if (s_axi_araddr == ACC_OFS_CONFIG) begin
                next_st.rdata[7:0] = st.config_reg;
            end else if (s_axi_araddr == ACC_OFS_PIN_LOW) begin
                next_st.rdata[7:0] = st.pin_low;
            end else if (s_axi_araddr == ACC_OFS_PIN_MID) begin
                next_st.rdata[7:0] = st.pin_mid;
            end else if (s_axi_araddr == ACC_OFS_CMP_CTRL) begin
                next_st.rdata[1:0] = st.cmp_ctrl;
            end else if (s_axi_araddr == ACC_OFS_RESULT) begin
                next_st.rdata[11:0] = st.result;
            end else begin
                next_st.rresp = ACC_RESP_SLVERR;
            end
        end
        next_st.arready = ~next_st.rvalid;

        // capture a finished conversion, filtered by the compare when enabled
        next_st.result_update = 1'b0;

        if (conv_done) begin
            if (!st.cmp_ctrl[ACC_CTL_ENABLE]) begin
                next_st.result        = cmp_masked;
                next_st.result_update = 1'b1;
            end else if (cmp_hit) begin
                next_st.result        = cmp_diff; // [RL14]
                next_st.result_update = 1'b1;
            end
        end

        // pad synchroniser, second stage is the only reader of the first
        next_st.pad_s1 = pad_in;
        next_st.pad_s2 = st.pad_s1;

        // handed pins lose port drive, port read and pull-up
        next_st.pad_out    = port_out;
        next_st.pad_oe_n   = port_oe_n | handed; // [RL12] [RL15]
        next_st.pad_pullup = port_pullup & ~handed; // [RL15]
        next_st.port_in    = st.pad_s2 & ~handed; // [RL15]
    end

    // every control bit clears on reset, selecting bus clock, divide 1, 8-bit
    always_ff @(posedge clk) begin
        if (srst) begin
            st            <= '0;

            st.awready    <= 1'b1;
            st.wready     <= 1'b1;
            st.arready    <= 1'b1;

            st.cmp_high   <= ACC_RST_CMP_HI; // [RL16]
            st.cmp_low    <= ACC_RST_REG8; // [RL16]
            st.config_reg <= ACC_RST_REG8; // [RL16]
            st.pin_low    <= ACC_RST_REG8; // [RL16]
            st.pin_mid    <= ACC_RST_REG8; // [RL16]

            st.cmp_ctrl   <= ACC_RST_CTRL;
            st.result     <= ACC_RST_RESULT;
            st.pad_oe_n   <= 16'hFFFF;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready      = st.awready;
    assign s_axi_wready       = st.wready;
    assign s_axi_bvalid       = st.bvalid;
    assign s_axi_bresp        = st.bresp;
    assign s_axi_arready      = st.arready;
    assign s_axi_rvalid       = st.rvalid;
    assign s_axi_rdata        = st.rdata;
    assign s_axi_rresp        = st.rresp;

    assign low_power_select   = st.config_reg[ACC_CFG_LOW_POWER]; // [RL5]
    assign long_sample_select = st.config_reg[ACC_CFG_LONG_SAMPLE]; // [RL7]

    assign conversion_mode    = st.config_reg[ACC_CFG_MODE_HI:ACC_CFG_MODE_LO]; // [RL8]

    assign result_update      = st.result_update;

    assign pad_out            = st.pad_out;
    assign pad_oe_n           = st.pad_oe_n;
    assign pad_pullup         = st.pad_pullup;
    assign port_in            = st.port_in;
    assign analog_select      = handed; // [RL12]

endmodule
`default_nettype wire

/* rtl/acc_pkg.sv */
// acc_pkg: shared constants, types and helpers of the converter configuration block
package acc_pkg;

    // bus geometry
    localparam int unsigned ACC_ADDR_W = 8;
    localparam int unsigned ACC_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] ACC_OFS_CMP_HIGH = 8'h00;
    localparam logic [7:0] ACC_OFS_CMP_LOW  = 8'h04;
    localparam logic [7:0] ACC_OFS_CONFIG   = 8'h08;
    localparam logic [7:0] ACC_OFS_PIN_LOW  = 8'h0C;
    localparam logic [7:0] ACC_OFS_PIN_MID  = 8'h10;
    localparam logic [7:0] ACC_OFS_CMP_CTRL = 8'h14;
    localparam logic [7:0] ACC_OFS_RESULT   = 8'h18;

    // configuration field positions
    localparam int unsigned ACC_CFG_LOW_POWER   = 7;
    localparam int unsigned ACC_CFG_DIV_HI      = 6;
    localparam int unsigned ACC_CFG_DIV_LO      = 5;
    localparam int unsigned ACC_CFG_LONG_SAMPLE = 4;
    localparam int unsigned ACC_CFG_MODE_HI     = 3;
    localparam int unsigned ACC_CFG_MODE_LO     = 2;
    localparam int unsigned ACC_CFG_CLK_HI      = 1;
    localparam int unsigned ACC_CFG_CLK_LO      = 0;

    // compare control field positions
    localparam int unsigned ACC_CTL_ENABLE  = 0;
    localparam int unsigned ACC_CTL_GREATER = 1;

    // implemented width of the compare-high register
    localparam int unsigned ACC_CMP_HIGH_W = 4;

    // values after reset
    localparam logic [7:0]  ACC_RST_REG8    = 8'h00;
    localparam logic [3:0]  ACC_RST_CMP_HI  = 4'h0;
    localparam logic [1:0]  ACC_RST_CTRL    = 2'h0;
    localparam logic [11:0] ACC_RST_RESULT  = 12'h000;
    localparam logic [15:0] ACC_RST_PINS    = 16'h0000;
    localparam logic [2:0]  ACC_RST_DIV_CNT = 3'h0;

    // bus responses
    localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

    // resolution modes
    typedef enum logic [1:0] {
        ACC_MODE_8  = 2'b00,
        ACC_MODE_12 = 2'b01,
        ACC_MODE_10 = 2'b10,
        ACC_MODE_RS = 2'b11
    } acc_mode_t;

    // divider source selection
    typedef enum logic [1:0] {
        ACC_SRC_BUS   = 2'b00,
        ACC_SRC_HALF  = 2'b01,
        ACC_SRC_ALT   = 2'b10,
        ACC_SRC_ASYNC = 2'b11
    } acc_src_t;

    // result bits that carry meaning in a given mode
    function automatic logic [11:0] acc_mode_mask(input logic [1:0] mode);
        logic [11:0] m;
        m = 12'h0FF;
        if (mode == ACC_MODE_12) begin
            m = 12'hFFF;
        end else if (mode == ACC_MODE_10) begin
            m = 12'h3FF;
        end
        return m;
    endfunction

    // terminal count of the divider, source pulses minus one
    function automatic logic [2:0] acc_div_last(input logic [1:0] sel);
        logic [2:0] t;
        t = 3'h0;
        case (sel)
            2'b01:   t = 3'h1;
            2'b10:   t = 3'h3;
            2'b11:   t = 3'h7;
            default: t = 3'h0;
        endcase
        return t;
    endfunction

endpackage

/* sim/acc_config_monitor.sv */
// acc_config_monitor: port-level assertions of the converter configuration block
`timescale 1ns/1ps
`default_nettype none
module acc_config_monitor
    import acc_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        conv_done,
    input wire logic        result_update,
    input wire logic [15:0] port_out,
    input wire logic [15:0] port_oe_n,
    input wire logic [15:0] port_pullup,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe_n,
    input wire logic [15:0] pad_pullup,
    input wire logic [15:0] port_in,
    input wire logic [15:0] analog_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // write taken, no response pending
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // pin outputs lag one clock
    pin_pull_a:
        assert property (!$past(srst) |-> pad_pullup == ($past(port_pullup) & ~$past(analog_select)))
        else $error("pull-up on handed pin");
    pin_drive_a:
        assert property (!$past(srst) |-> pad_oe_n == ($past(port_oe_n) | $past(analog_select)))
        else $error("pad drive wrong");
    pin_read_a:
        assert property ((port_in & $past(analog_select)) == 16'h0000)
        else $error("handed pin read");
    pin_out_a:
        assert property (!$past(srst) |-> pad_out == $past(port_out))
        else $error("pad data wrong");
    update_cause_a:
        assert property (result_update |-> $past(conv_done))
        else $error("update without conversion");
    cmp_high_rd_a:
        assert property (rd_taken ##0 s_axi_araddr == ACC_OFS_CMP_HIGH |=> s_axi_rdata[31:4] == 28'h0)
        else $error("high bits not zero");
    rd_answer_a:
        assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    rd_unmapped_a:
        assert property (rd_taken ##0 s_axi_araddr >= 8'h1C
            |=> s_axi_rresp == ACC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read taken");
    wr_answer_a:
        assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
endmodule

bind acc_config acc_config_monitor acc_config_monitor_inst (.*);
`default_nettype wire

/* sim/tb_top.sv */
// tb_top: self-checking bench of the converter configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        comparisons++; \
        if ((got) !== (ex)) begin \
            error_cnt++; \
            $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module tb_top
    import acc_pkg::*;
;
    logic        clk = 1'h0, srst = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, conversion_mode;
    logic        conv_done = 1'h0, alternate_clock = 1'h0, converter_async_clock = 1'h0;
    logic [11:0] conv_result = 12'h000;
    logic        low_power_select, long_sample_select, converter_clock_en, result_update;
    logic [15:0] port_out = 16'h0000, port_oe_n = 16'hFFFF, port_pullup = 16'h0000;
    logic [15:0] pad_in = 16'h0000;
    logic [15:0] pad_out, pad_oe_n, pad_pullup, port_in, analog_select;
    logic [2:0]  cyc = 3'h0;
    int          error_cnt = 0, comparisons = 0;

    acc_config acc_config_inst (.*);

    // bus clock, 40 ns period
    always #20 clk = ~clk;
    // slow sources: alternate every 4 cycles, async every 8
    always @(posedge clk) begin
        cyc <= cyc + 3'h1;
        alternate_clock <= cyc[1];
        converter_async_clock <= cyc[2];
    end

    task report_and_stop;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one write; each half released when taken
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end while (!(s_axi_bvalid === 1'h1 && aw_ok && w_ok));
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_ok;
        ar_ok = 1'h0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (!ar_ok && s_axi_arready) begin
                ar_ok = 1'h1;
                s_axi_arvalid <= 1'h0;
            end
        end while (!(s_axi_rvalid === 1'h1 && ar_ok));
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'h0;
    endtask

    // converter clock pulses in 64 cycles
    task automatic t_clock(input logic [1:0] src, input logic [1:0] dv, input logic [7:0] ex);
        logic [7:0] cnt;
        cnt = 8'h00;
        wr_chk(ACC_OFS_CONFIG, {24'h0, 1'h0, dv, 1'h0, 2'h0, src}, ACC_RESP_OKAY);
        repeat (16) @(posedge clk);
        repeat (64) begin
            @(negedge clk);
            cnt = cnt + {7'h0, converter_clock_en};
        end
        `CHK("clock pulses", ex, cnt)
    endtask

    // one conversion, then the result read back
    task automatic t_cmp(input logic [1:0] md, input logic [7:0] hi, input logic [7:0] lo,
                         input logic [1:0] ctl, input logic [11:0] raw,
                         input logic [3:0] upd, input logic [11:0] res);
        logic [3:0] n;
        n = 4'h0;
        wr_chk(ACC_OFS_CONFIG, {28'h0, md, 2'h0}, ACC_RESP_OKAY);
        wr_chk(ACC_OFS_CMP_HIGH, {24'h0, hi}, ACC_RESP_OKAY);
        wr_chk(ACC_OFS_CMP_LOW, {24'h0, lo}, ACC_RESP_OKAY);
        wr_chk(ACC_OFS_CMP_CTRL, {30'h0, ctl}, ACC_RESP_OKAY);
        @(posedge clk);
        conv_result <= raw;
        conv_done <= 1'h1;
        @(posedge clk);
        conv_done <= 1'h0;
        repeat (3) begin
            @(negedge clk);
            n = n + {3'h0, result_update};
        end
        `CHK("update pulses", upd, n)
        rd_chk(ACC_OFS_RESULT, {20'h0, res}, ACC_RESP_OKAY);
    endtask

    // pins handed over: channels 0, 7 and 9
    task automatic t_pins;
        wr_chk(ACC_OFS_PIN_LOW, 32'h81, ACC_RESP_OKAY);
        wr_chk(ACC_OFS_PIN_MID, 32'h02, ACC_RESP_OKAY);
        port_out <= 16'hFFFF;
        port_oe_n <= 16'h0000;
        port_pullup <= 16'hFFFF;
        pad_in <= 16'hFFFF;
        repeat (5) @(negedge clk);
        `CHK("analog_select", 16'h0281, analog_select)
        `CHK("pad_oe_n", 16'h0281, pad_oe_n)
        `CHK("pad_pullup", 16'hFD7E, pad_pullup)
        `CHK("port_in", 16'hFD7E, port_in)
        `CHK("pad_out", 16'hFFFF, pad_out)
        rd_chk(ACC_OFS_PIN_MID, 32'h02, ACC_RESP_OKAY);
    endtask

    task automatic t_regs;
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'(i * 4), 32'h0, ACC_RESP_OKAY);
        end
        `CHK("pad_oe_n", 16'hFFFF, pad_oe_n)
        wr_chk(ACC_OFS_CONFIG, 32'h80, ACC_RESP_OKAY);
        `CHK("low_power", 1'h1, low_power_select)
        `CHK("long_sample", 1'h0, long_sample_select)
        wr_chk(ACC_OFS_CONFIG, 32'h10, ACC_RESP_OKAY);
        `CHK("low_power", 1'h0, low_power_select)
        `CHK("long_sample", 1'h1, long_sample_select)
        for (int m = 0; m < 4; m++) begin
            wr_chk(ACC_OFS_CONFIG, 32'(m * 4), ACC_RESP_OKAY);
            `CHK("mode", 2'(m), conversion_mode)
        end
        wr_chk(ACC_OFS_CMP_HIGH, 32'hFF, ACC_RESP_OKAY);
        rd_chk(ACC_OFS_CMP_HIGH, 32'h0F, ACC_RESP_OKAY);
        wr_chk(8'h40, 32'h12, ACC_RESP_SLVERR);
        rd_chk(8'h40, 32'h0, ACC_RESP_SLVERR);
    endtask

    // watchdog, run needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        t_regs();
        for (int d = 0; d < 4; d++) begin
            t_clock(2'h0, 2'(d), 8'(64 >> d));
        end
        t_clock(2'h1, 2'h0, 8'h20);
        t_clock(2'h1, 2'h1, 8'h10);
        t_clock(2'h2, 2'h0, 8'h10);
        t_clock(2'h3, 2'h0, 8'h08);
        t_cmp(2'h1, 8'h00, 8'h00, 2'h0, 12'hABC, 4'h1, 12'hABC);
        t_cmp(2'h0, 8'h00, 8'h00, 2'h0, 12'hABC, 4'h1, 12'h0BC);
        t_cmp(2'h1, 8'h03, 8'h45, 2'h1, 12'h344, 4'h1, 12'hFFF);
        t_cmp(2'h1, 8'h03, 8'h45, 2'h1, 12'h345, 4'h0, 12'hFFF);
        t_cmp(2'h1, 8'h03, 8'h45, 2'h3, 12'h345, 4'h1, 12'h000);
        t_cmp(2'h1, 8'h03, 8'h45, 2'h3, 12'h344, 4'h0, 12'h000);
        t_cmp(2'h2, 8'hFF, 8'h45, 2'h3, 12'h3FF, 4'h1, 12'h0BA);
        t_cmp(2'h0, 8'hFF, 8'h45, 2'h3, 12'hF50, 4'h1, 12'h00B);
        t_cmp(2'h0, 8'h00, 8'h45, 2'h1, 12'h050, 4'h0, 12'h00B);
        t_pins();
        report_and_stop();
    end
endmodule
`default_nettype wire
